// *** core/cis_defines.vh ***
// Constants for the instruction sequencer: opcodes, flag bit positions,
// reset values, and clock-period counts.
// Assumes inclusion by bare name from the design files.
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH

// --------------------------------------------------------------------------
// Opcodes
// --------------------------------------------------------------------------
`define CIS_OP_ADD_REG   5'h10
`define CIS_OP_AND_REG   5'h14
`define CIS_OP_CMP_REG   5'h17
`define CIS_OP_ADD_IMM   8'hc6
`define CIS_OP_AND_IMM   8'he6
`define CIS_OP_CALL      8'hcd
`define CIS_OP_INV_ACC   8'h2f
`define CIS_OP_INV_CY    8'h3f
`define CIS_SRC_MEM      3'h6
`define CIS_SRC_ACC      3'h7

// --------------------------------------------------------------------------
// Flag positions in the status byte
// --------------------------------------------------------------------------
`define CIS_FLAG_CY      0
`define CIS_FLAG_P       2
`define CIS_FLAG_AC      4
`define CIS_FLAG_Z       6
`define CIS_FLAG_S       7

// --------------------------------------------------------------------------
// Reset values and clock-period counts
// --------------------------------------------------------------------------
`define CIS_RST_BYTE     8'h00
`define CIS_RST_WORD     16'h0000
`define CIS_RST_FLAGS    8'h02
`define CIS_CLKS_SHORT   4
`define CIS_CLKS_MEM     7

`endif

// *** core/cis_alu.v ***
// Eight-bit arithmetic and logic unit for the instruction sequencer.
// Assumes its operands are held stable by the caller for one cycle.
`timescale 1ns/10ps
`include "cis_defines.vh"

module cis_alu
(
    input  wire [1:0] op,
    input  wire [7:0] act,
    input  wire [7:0] tmp,
    output reg  [7:0] res,
    output reg        cy,
    output reg        ac,
    output wire       zf,
    output wire       sf,
    output wire       pf
);

    reg [8:0] wide;
    reg [4:0] nib;

    // ----------------------------------------------------------------------
    // Operation select: 0 add, 1 and, 2 compare (subtract).
    // ----------------------------------------------------------------------
    // Compare borrows are the inverse of the carry out of a two's
    // complement add, which is why cy is inverted for op 2.
    always @*
    begin
        wide = 9'h000;
        nib  = 5'h00;
        res  = 8'h00;
        cy   = 1'b0;
        ac   = 1'b0;
        case (op)
            2'd0:
            begin
                wide = {1'b0, act} + {1'b0, tmp};
                nib  = {1'b0, act[3:0]} + {1'b0, tmp[3:0]};
                res  = wide[7:0];
                cy   = wide[8];
                ac   = nib[4];
            end
            2'd1:
            begin
                res = act & tmp;
                // Carry clear, aux from bit 3.
                cy  = 1'b0;
                ac  = act[3] | tmp[3];
            end
            2'd2:
            begin
                wide = {1'b0, act} + {1'b0, ~tmp} + 9'h001;
                nib  = {1'b0, act[3:0]} + {1'b0, ~tmp[3:0]} + 5'h01;
                res  = wide[7:0];
                cy   = ~wide[8];
                ac   = nib[4];
            end
            default:
            begin
                res = act;
            end
        endcase
    end

    // Flags read straight off the result.
    assign zf = (res == 8'h00);
    assign sf = res[7];
    assign pf = ~^res;

endmodule

// *** core/cis_sequencer.v ***
// Execution sequencer for add, and, compare, call, and the two
// complement instructions of an eight-bit processor.
// Assumes memory answers a read in the T3 state it is asked in, and that
// all inputs are synchronous to clk.
`timescale 1ns/10ps
`include "cis_defines.vh"

module cis_sequencer
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire [7:0]  data_in,
    input  wire [7:0]  reg_file_b,
    input  wire [7:0]  reg_file_c,
    input  wire [7:0]  reg_file_d,
    input  wire [7:0]  reg_file_e,
    input  wire [7:0]  reg_file_h,
    input  wire [7:0]  reg_file_l,
    output reg  [15:0] addr_out,
    output reg  [7:0]  data_out,
    output reg         data_oe_n,
    output reg         status_valid,
    output reg         mem_read,
    output reg         mem_write,
    output reg  [2:0]  t_state,
    output reg  [2:0]  m_cycle,
    output reg  [7:0]  acc_out,
    output reg  [7:0]  flags_out,
    output reg  [15:0] pc_out,
    output reg  [15:0] stack_pointer_out
);

    // ----------------------------------------------------------------------
    // State codes
    // ----------------------------------------------------------------------
    localparam [2:0] T1 = 3'd1;
    localparam [2:0] T2 = 3'd2;
    localparam [2:0] T3 = 3'd3;
    localparam [2:0] T4 = 3'd4;
    localparam [2:0] T5 = 3'd5;
    localparam [2:0] M1 = 3'd1;
    localparam [2:0] M2 = 3'd2;
    localparam [2:0] M3 = 3'd3;
    localparam [2:0] M4 = 3'd4;
    localparam [2:0] M5 = 3'd5;
    localparam [1:0] PEND_NONE = 2'd0;
    localparam [1:0] PEND_ADD  = 2'd1;
    localparam [1:0] PEND_AND  = 2'd2;
    localparam [1:0] PEND_CMP  = 2'd3;

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    reg [2:0]  t_q;
    reg [2:0]  m_q;
    reg [7:0]  ir_q;
    reg [7:0]  acc_q;
    reg [7:0]  act_q;
    reg [7:0]  tmp_q;
    reg [7:0]  flg_q;
    reg [15:0] pc_q;
    reg [15:0] sp_q;
    reg [7:0]  w_q;
    reg [7:0]  z_q;
    reg [1:0]  pend_q;
    reg        jump_q;
    reg        cond_q;

    wire [7:0] alu_res;
    wire       alu_cy;
    wire       alu_ac;
    wire       alu_z;
    wire       alu_s;
    wire       alu_p;
    wire [1:0] alu_op;

    // ----------------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------------
    // Picks a register by its three-bit source code; memory reads zero.
    function [7:0] src_sel;
        input [2:0] code;
        input [7:0] accv;
        begin
            case (code)
                3'd0:    src_sel = reg_file_b;
                3'd1:    src_sel = reg_file_c;
                3'd2:    src_sel = reg_file_d;
                3'd3:    src_sel = reg_file_e;
                3'd4:    src_sel = reg_file_h;
                3'd5:    src_sel = reg_file_l;
                3'd7:    src_sel = accv;
                default: src_sel = 8'h00;
            endcase
        end
    endfunction

    // Evaluates the call condition from opcode bits 5..3 and the flags.
    function cond_ok;
        input [7:0] op;
        input [7:0] f;
        begin
            case (op[5:4])
                2'd0:    cond_ok = f[`CIS_FLAG_Z]  == op[3];
                2'd1:    cond_ok = f[`CIS_FLAG_CY] == op[3];
                2'd2:    cond_ok = f[`CIS_FLAG_P]  == op[3];
                default: cond_ok = f[`CIS_FLAG_S]  == op[3];
            endcase
        end
    endfunction

    // Classifies the latched opcode.
    function [2:0] kind_of;
        input [7:0] op;
        begin
            if (op[7:3] == `CIS_OP_ADD_REG)
                kind_of = 3'd1;
            else if (op[7:3] == `CIS_OP_AND_REG)
                kind_of = 3'd2;
            else if (op[7:3] == `CIS_OP_CMP_REG)
                kind_of = 3'd3;
            else if (op == `CIS_OP_ADD_IMM || op == `CIS_OP_AND_IMM)
                kind_of = 3'd4;
            else if (op == `CIS_OP_CALL ||
                     (op[7:6] == 2'b11 && op[2:0] == 3'b100))
                kind_of = 3'd5;
            else
                kind_of = 3'd0;
        end
    endfunction

    wire [2:0] kind  = kind_of(ir_q);
    wire       memsrc = (ir_q[2:0] == `CIS_SRC_MEM);
    wire       is_uncond = (ir_q == `CIS_OP_CALL);

    assign alu_op = (pend_q == PEND_AND) ? 2'd1 :
                    (pend_q == PEND_CMP) ? 2'd2 : 2'd0;

    cis_alu u_alu
    (
        .op  (alu_op),
        .act (act_q),
        .tmp (tmp_q),
        .res (alu_res),
        .cy  (alu_cy),
        .ac  (alu_ac),
        .zf  (alu_z),
        .sf  (alu_s),
        .pf  (alu_p)
    );

    // ----------------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------------
    // One T state per clock. Each register loads only in the states that assign it; the
    // bus outputs are registered so they trail the state by one cycle,
    // which the far side must allow for.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            t_q          <= T1;
            m_q          <= M1;
            ir_q         <= `CIS_RST_BYTE;
            acc_q        <= `CIS_RST_BYTE;
            act_q        <= `CIS_RST_BYTE;
            tmp_q        <= `CIS_RST_BYTE;
            flg_q        <= `CIS_RST_FLAGS;
            pc_q         <= `CIS_RST_WORD;
            sp_q         <= `CIS_RST_WORD;
            w_q          <= `CIS_RST_BYTE;
            z_q          <= `CIS_RST_BYTE;
            pend_q       <= PEND_NONE;
            jump_q       <= 1'b0;
            cond_q       <= 1'b0;
            addr_out     <= `CIS_RST_WORD;
            data_out     <= `CIS_RST_BYTE;
            data_oe_n    <= 1'b1;
            status_valid <= 1'b0;
            mem_read     <= 1'b0;
            mem_write    <= 1'b0;
        end
        else
        begin
            status_valid <= 1'b0;
            mem_read     <= 1'b0;
            mem_write    <= 1'b0;
            data_oe_n    <= 1'b1;
            case (t_q)
                T1:
                begin
                    status_valid <= 1'b1;
                    if (m_q == M1 && jump_q)
                        addr_out <= {w_q, z_q};
                    else if (m_q == M2 && kind != 3'd4 && kind != 3'd5)
                        addr_out <= {reg_file_h, reg_file_l};
                    else if (m_q == M4 || m_q == M5)
                        addr_out <= sp_q;
                    else
                        addr_out <= pc_q;
                    t_q <= T2;
                end
                T2:
                begin
                    if (m_q == M1)
                    begin
                        pc_q   <= (jump_q ? {w_q, z_q} : pc_q) + 16'h0001;
                        jump_q <= 1'b0;
                        mem_read <= 1'b1;
                        // Deferred results land here, in the next fetch.
                        // Add or AND result written to the accumulator this T2.
                        if (pend_q == PEND_ADD || pend_q == PEND_AND)
                            acc_q <= alu_res;
                        if (pend_q != PEND_NONE)
                        begin
                            flg_q[`CIS_FLAG_Z]  <= alu_z;
                            flg_q[`CIS_FLAG_S]  <= alu_s;
                            flg_q[`CIS_FLAG_P]  <= alu_p;
                            flg_q[`CIS_FLAG_CY] <= alu_cy;
                            flg_q[`CIS_FLAG_AC] <= alu_ac;
                        end
                        pend_q <= PEND_NONE;
                    end
                    else if (m_q == M4)
                    begin
                        sp_q      <= sp_q - 16'h0001;
                        data_out  <= pc_q[15:8];
                        data_oe_n <= 1'b0;
                        mem_write <= 1'b1;
                    end
                    else if (m_q == M5)
                    begin
                        data_out  <= pc_q[7:0];
                        data_oe_n <= 1'b0;
                        mem_write <= 1'b1;
                    end
                    else
                    begin
                        mem_read <= 1'b1;
                        if (kind == 3'd4 || kind == 3'd5)
                            pc_q <= pc_q + 16'h0001;
                    end
                    t_q <= T3;
                end
                T3:
                begin
                    t_q <= T1;
                    if (m_q == M1)
                    begin
                        ir_q <= data_in;
                        t_q  <= T4;
                    end
                    else if (m_q == M2)
                    begin
                        if (kind == 3'd5)
                        begin
                            z_q <= data_in;
                            m_q <= M3;
                        end
                        else
                        begin
                            tmp_q <= data_in;
                            m_q   <= M1;
                        end
                    end
                    else if (m_q == M3)
                    begin
                        w_q <= data_in;
                        m_q <= cond_q ? M4 : M1;
                    end
                    else if (m_q == M4)
                        m_q <= M5;
                    else
                    begin
                        jump_q <= 1'b1;
                        m_q    <= M1;
                    end
                end
                T4:
                begin
                    t_q <= T1;
                    m_q <= M1;
                    case (kind)
                        3'd1, 3'd2, 3'd3:
                        begin
                            act_q  <= acc_q;
                            tmp_q  <= src_sel(ir_q[2:0], acc_q);
                            m_q    <= memsrc ? M2 : M1;
                            pend_q <= (kind == 3'd1) ? PEND_ADD :
                                      (kind == 3'd2) ? PEND_AND : PEND_CMP;
                        end
                        3'd4:
                        begin
                            act_q  <= acc_q;
                            m_q    <= M2;
                            pend_q <= ir_q[5] ? PEND_AND : PEND_ADD;
                        end
                        3'd5:
                        begin
                            cond_q <= is_uncond | cond_ok(ir_q, flg_q);
                            m_q    <= M2;
                            t_q    <= T5;
                        end
                        default:
                        begin
                            if (ir_q == `CIS_OP_INV_ACC)
                                acc_q <= ~acc_q;
                            if (ir_q == `CIS_OP_INV_CY)
                                flg_q[`CIS_FLAG_CY] <=
                                    ~flg_q[`CIS_FLAG_CY];
                        end
                    endcase
                end
                T5:
                begin
                    if (cond_q)
                        sp_q <= sp_q - 16'h0001;
                    t_q <= T1;
                end
                default:
                begin
                    t_q <= T1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Visible state, registered so every output is a flip-flop.
    // ----------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            t_state           <= T1;
            m_cycle           <= M1;
            acc_out           <= `CIS_RST_BYTE;
            flags_out         <= `CIS_RST_FLAGS;
            pc_out            <= `CIS_RST_WORD;
            stack_pointer_out <= `CIS_RST_WORD;
        end
        else
        begin
            t_state           <= t_q;
            m_cycle           <= m_q;
            acc_out           <= acc_q;
            flags_out         <= flg_q;
            pc_out            <= pc_q;
            stack_pointer_out <= sp_q;
        end
    end

endmodule

// *** sim/cis_seq_assertions.sv ***
// Concurrent checks on the sequencer bus and state outputs.
// Assumes binding to the sequencer top; sees its ports only.
`timescale 1ns/10ps
module cis_seq_checker
(
    input wire        clk,
    input wire        rst_n,
    input wire [15:0] addr_out,
    input wire [7:0]  data_out,
    input wire        data_oe_n,
    input wire        status_valid,
    input wire        mem_read,
    input wire        mem_write,
    input wire [2:0]  t_state,
    input wire [2:0]  m_cycle,
    input wire [15:0] pc_out,
    input wire [15:0] stack_pointer_out
);
// --------------------------------------------------------------------
// Bus cycle shape
// --------------------------------------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
property p_stat;
    status_valid |-> t_state == 3'h1;
endproperty
a_stat: assert property (p_stat)
    else $error("status strobe outside first state");
property p_read;
    mem_read |-> t_state == 3'h2 && data_oe_n;
endproperty
a_read: assert property (p_read)
    else $error("read strobe misplaced or bus driven");
property p_short;
    t_state == 3'h3 && m_cycle != 3'h1 |=> t_state == 3'h1;
endproperty
a_short: assert property (p_short)
    else $error("non-fetch cycle longer than three states");
property p_fetch_len;
    m_cycle == 3'h1 && t_state == 3'h4 |=> t_state inside {3'h1, 3'h5};
endproperty
a_fetch_len: assert property (p_fetch_len)
    else $error("fetch cycle state order wrong");
property p_pc_step;
    $rose(mem_read) && m_cycle == 3'h1
        |-> ##[0:2] pc_out == addr_out + 16'h0001;
endproperty
a_pc_step: assert property (p_pc_step)
    else $error("counter not one past fetch address");
property p_wr_cyc;
    mem_write |-> !data_oe_n && m_cycle inside {3'h4, 3'h5};
endproperty
a_wr_cyc: assert property (p_wr_cyc)
    else $error("write outside push cycles");
property p_push_hi;
    mem_write && m_cycle == 3'h4 |-> data_out == pc_out[15:8];
endproperty
a_push_hi: assert property (p_push_hi)
    else $error("first push byte is not counter high");
property p_push_lo;
    mem_write && m_cycle == 3'h5
        |-> data_out == pc_out[7:0] && addr_out == stack_pointer_out;
endproperty
a_push_lo: assert property (p_push_lo)
    else $error("second push byte or address wrong");
property p_sp_dec;
    !$stable(stack_pointer_out)
        |-> stack_pointer_out == $past(stack_pointer_out) - 16'h0001;
endproperty
a_sp_dec: assert property (p_sp_dec)
    else $error("stack pointer moved by other than one down");
c_mem_op: cover property (status_valid && m_cycle == 3'h2);
c_push: cover property (mem_write && m_cycle == 3'h5);
c_long_m1: cover property (m_cycle == 3'h1 && t_state == 3'h5);
endmodule

// *** sim/cis_mem_model.sv ***
// Behavioural memory on the far side of the sequencer bus.
// Assumes reads answer in the strobe cycle, writes land on the edge.
`timescale 1ns/10ps
module cis_mem_model
(
    input  wire        clk,
    input  wire [15:0] addr,
    input  wire [7:0]  wdata,
    input  wire        rd,
    input  wire        wr,
    output wire [7:0]  rdata
);
reg [7:0] mem [0:65535];
reg [7:0] last_q;
integer   i;
// Clear memory so unloaded bytes run as filler.
initial
begin
    for (i = 0; i < 65536; i = i + 1)
        mem[i] = 8'h00;
    last_q = 8'h00;
end
// An idle bus shows the inverse of the last byte, so no stale match.
assign rdata = rd ? mem[addr] : ~last_q;
// Stack bytes land on the strobe; the last read byte is remembered.
always @(posedge clk)
begin
    if (wr)
        mem[addr] <= wdata;
    if (rd)
        last_q <= mem[addr];
end
endmodule

// *** sim/tb.sv ***
// Bench for the sequencer: runs short programs, checks results.
// Assumes the memory model and the checker compile alongside.
`timescale 1ns/10ps
`define CIS_CHK(nm, e, g) \
begin \
    total_checks = total_checks + 1; \
    if ((g) !== (e)) \
    begin \
        failures = failures + 1; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
end
module tb;
reg         clk;
reg         rst_n;
reg  [7:0]  reg_b;
reg  [7:0]  reg_c;
reg  [7:0]  reg_h;
wire [7:0]  data_in;
wire [15:0] addr_out;
wire [7:0]  data_out;
wire        data_oe_n;
wire        status_valid;
wire        mem_read;
wire        mem_write;
wire [2:0]  t_state;
wire [2:0]  m_cycle;
wire [7:0]  acc_out;
wire [7:0]  flags_out;
wire [15:0] pc_out;
wire [15:0] stack_pointer_out;
integer     failures;
integer     total_checks;
integer     cyc;
integer     nst;
integer     starts [0:15];
cis_sequencer dut_u (.clk(clk), .rst_n(rst_n), .data_in(data_in),
    .reg_file_b(reg_b), .reg_file_c(reg_c), .reg_file_d(8'h11),
    .reg_file_e(8'h22), .reg_file_h(reg_h), .reg_file_l(8'h00),
    .addr_out(addr_out), .data_out(data_out), .data_oe_n(data_oe_n),
    .status_valid(status_valid), .mem_read(mem_read),
    .mem_write(mem_write), .t_state(t_state), .m_cycle(m_cycle),
    .acc_out(acc_out), .flags_out(flags_out), .pc_out(pc_out),
    .stack_pointer_out(stack_pointer_out));
cis_mem_model mem_u (.clk(clk), .addr(addr_out), .wdata(data_out),
    .rd(mem_read), .wr(mem_write), .rdata(data_in));
// 250 MHz clock.
initial
begin
    clk = 1'b0;
    forever #2 clk = ~clk;
end
// Log each instruction start; a hung run is cut short here.
always @(posedge clk)
begin
    cyc = cyc + 1;
    if (rst_n && status_valid === 1'b1 && m_cycle === 3'h1 && nst < 16)
    begin
        starts[nst] = cyc;
        nst = nst + 1;
    end
    if (cyc > 3000)
    begin
        failures = failures + 1;
        wrap_up;
    end
end
// Place a program, then four filler bytes that run as no-ops.
task load(input [15:0] base, input [63:0] bytes, input integer n);
    integer i;
    begin
        for (i = 0; i < n + 4; i = i + 1)
            mem_u.mem[base + i] = (i < n) ? bytes[8 * (n - 1 - i) +: 8]
                                          : 8'h00;
    end
endtask
// Reset is held ten cycles; timing log restarts with the program.
task reset_run;
    begin
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        nst = 0;
        rst_n = 1'b1;
    end
endtask
// Wait, bounded, until the counter passes the program's end.
task run_to(input [15:0] pc_end);
    integer k;
    begin
        k = 0;
        while (pc_out !== pc_end && k < 400)
        begin
            @(negedge clk);
            k = k + 1;
        end
        `CIS_CHK("end address", pc_end, pc_out)
        repeat (4) @(negedge clk);
    end
endtask
// Clock periods between instruction starts, first in the low byte.
task chk_lens(input [63:0] lens, input integer n);
    integer i;
    begin
        for (i = 0; i < n; i = i + 1)
            `CIS_CHK("periods", lens[8 * i +: 8],
                     starts[i + 1] - starts[i])
    end
endtask
task wrap_up;
    begin
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
endtask
// --------------------------------------------------------------------
// Test sequence
// --------------------------------------------------------------------
initial
begin
    rst_n = 1'b0;
    reg_b = 8'h00;
    reg_c = 8'h00;
    reg_h = 8'h01;
    failures = 0;
    total_checks = 0;
    cyc = 0;
    nst = 0;
    @(negedge clk);
    // Register, memory and immediate add ending in carry and zero.
    reg_b = 8'h3c;
    mem_u.mem[16'h0100] = 8'hd0;
    load(16'h0000, 64'h8086c6f4, 4);
    reset_run;
    run_to(16'h0006);
    `CIS_CHK("acc", 8'h00, acc_out)
    `CIS_CHK("flags", 8'h57, flags_out)
    chk_lens({8'd7, 8'd7, 8'd4}, 3);
    $display("test add done");
    // AND forms after carry is set; carry must end clear.
    reg_b = 8'hf3;
    reg_c = 8'h3c;
    mem_u.mem[16'h0100] = 8'hf0;
    load(16'h0000, 64'h803fa1a6e60f, 6);
    reset_run;
    run_to(16'h0008);
    `CIS_CHK("acc", 8'h00, acc_out)
    `CIS_CHK("flags", 8'h56, flags_out)
    chk_lens({8'd7, 8'd7, 8'd4, 8'd4, 8'd4}, 5);
    $display("test and done");
    // Invert, compare less then equal, then invert carry.
    reg_b = 8'h55;
    reg_c = 8'haa;
    load(16'h0000, 64'h802fbeb93f, 5);
    reset_run;
    run_to(16'h0007);
    `CIS_CHK("acc", 8'haa, acc_out)
    `CIS_CHK("flags", 5'h0f, {flags_out[7:6], flags_out[2:0]})
    chk_lens({8'd4, 8'd4, 8'd7, 8'd4, 8'd4}, 5);
    $display("test compare done");
    // Call, untaken conditional call, taken conditional call.
    load(16'h0000, 64'hcd3412, 3);
    load(16'h1234, 64'hcc0020c40020, 6);
    reset_run;
    run_to(16'h2002);
    `CIS_CHK("sp", 16'hfffc, stack_pointer_out)
    `CIS_CHK("push 1", 8'h00, mem_u.mem[16'hffff])
    `CIS_CHK("push 2", 8'h03, mem_u.mem[16'hfffe])
    `CIS_CHK("push 3", 8'h12, mem_u.mem[16'hfffd])
    `CIS_CHK("push 4", 8'h3a, mem_u.mem[16'hfffc])
    chk_lens({8'd17, 8'd11, 8'd17}, 3);
    $display("test call done");
    // Calls on carry set, parity even (untaken) and sign clear.
    load(16'h0000, 64'h3fdc1000, 4);
    load(16'h0010, 64'hec0030f40030, 6);
    reset_run;
    run_to(16'h3002);
    `CIS_CHK("sp", 16'hfffc, stack_pointer_out)
    `CIS_CHK("push 2", 8'h04, mem_u.mem[16'hfffe])
    `CIS_CHK("push 4", 8'h16, mem_u.mem[16'hfffc])
    chk_lens({8'd17, 8'd11, 8'd17, 8'd4}, 4);
    $display("test condition done");
    wrap_up;
end
endmodule
bind cis_sequencer cis_seq_checker chk_u (.clk(clk), .rst_n(rst_n),
    .addr_out(addr_out), .data_out(data_out), .data_oe_n(data_oe_n),
    .status_valid(status_valid), .mem_read(mem_read),
    .mem_write(mem_write), .t_state(t_state), .m_cycle(m_cycle),
    .pc_out(pc_out), .stack_pointer_out(stack_pointer_out));
